// ### rtl/icfc_cycle_ctrl.sv
`timescale 1ns/1ps
`include "icfc_regs.svh"
module icfc_cycle_ctrl
   import icfc_pkg::*;
#(
   parameter int PC_W = 12
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic instValid,
   input wire icfc_class_t instClass,
   input wire logic skipCond,
   input wire logic [7:0] operandAddr,
   input wire logic [3:0] aluFlags,
   input wire logic [3:0] stackFlags,
   input wire logic [PC_W-1:0] pcCur,
   input wire logic [7:0] acc,
   input wire logic [PC_W-1:0] jumpTarget,
   input wire logic [PC_W-1:0] stackPc,
   input wire logic irqEnter,
   output logic instReady,
   output logic retire,
   output logic slotSquash,
   output logic [1:0] instCycles,
   output logic [3:0] flags,
   output logic gie,
   output logic pcLoad,
   output logic [PC_W-1:0] pcNext,
   output logic [`ICFC_BIT_ADDR_W-1:0] bitAddr,
   output logic bitAddrErr
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [PC_W-1:0] addAcc(input logic [PC_W-1:0] pc,
                                               input logic [7:0] a);
      logic [PC_W+7:0] sum;
      sum = {8'h00, pc} + {{PC_W{1'b0}}, a};
      return sum[PC_W-1:0];
   endfunction

   function automatic logic bitInRange(input logic [7:0] addr);
      return addr <= `ICFC_BIT_ADDR_MAX;
   endfunction

   icfc_dec_if dec ();
   icfc_state_t state;
   logic accept;
   logic longInst;
   logic skipTaken;

   assign dec.instClass = instClass;
   assign accept = ce && instValid && (state == ICFC_ST_EXEC);
   assign skipTaken = dec.isSkip && skipCond;
   assign longInst = dec.isXfer || skipTaken;

   icfc_class_decode u_dec (
      .dec(dec.decoder)
   );

   // ----------------------------------------
   // Cycle sequencer
   // ----------------------------------------
   // One clock per instruction cycle; the second cycle never takes a new instruction
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= ICFC_ST_EXEC;
         instReady <= 1'b1;
         retire <= 1'b0;
         slotSquash <= 1'b0;
         instCycles <= `ICFC_CYC_SHORT;
      end else if (ce) begin
         case (state)
            ICFC_ST_EXEC: begin
               retire <= 1'b0;
               slotSquash <= 1'b0;
               if (instValid) begin
                  if (longInst) begin
                     state <= ICFC_ST_WAIT;
                     instReady <= 1'b0;
                     slotSquash <= skipTaken;
                     instCycles <= `ICFC_CYC_LONG;
                  end else begin
                     retire <= 1'b1;
                     instCycles <= `ICFC_CYC_SHORT;
                  end
               end
            end
            ICFC_ST_WAIT: begin
               state <= ICFC_ST_EXEC;
               instReady <= 1'b1;
               retire <= 1'b1;
               slotSquash <= 1'b0;
            end
            default: begin
               state <= ICFC_ST_EXEC;
               instReady <= 1'b1;
               retire <= 1'b0;
               slotSquash <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Status flags
   // ----------------------------------------
   // Flags move only on an accepted instruction, so the squashed slot cannot touch them
   always_ff @(posedge clk) begin
      if (rst) begin
         flags <= `ICFC_FLAGS_RST;
      end else if (accept) begin
         if (dec.isPop) begin
            flags <= stackFlags;
         end else begin
            flags <= (flags & ~dec.flagMask) | (aluFlags & dec.flagMask);
         end
      end
   end

   // ----------------------------------------
   // Program counter and interrupt enable
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         pcLoad <= 1'b0;
         pcNext <= '0;
      end else if (ce) begin
         pcLoad <= 1'b0;
         if (accept) begin
            case (instClass)
               ICFC_CL_PCADD: begin
                  pcLoad <= 1'b1;
                  pcNext <= addAcc(pcCur, acc);
               end
               ICFC_CL_RET, ICFC_CL_RETI: begin
                  pcLoad <= 1'b1;
                  pcNext <= stackPc;
               end
               ICFC_CL_GOTO, ICFC_CL_CALL: begin
                  pcLoad <= 1'b1;
                  pcNext <= jumpTarget;
               end
               default: begin
                  pcLoad <= 1'b0;
               end
            endcase
         end
      end
   end

   // Instruction enables win over an interrupt entry in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         gie <= `ICFC_GIE_RST;
      end else if (ce) begin
         if (accept && (instClass == ICFC_CL_RETI || instClass == ICFC_CL_ENGINT)) begin
            gie <= 1'b1;
         end else if (accept && instClass == ICFC_CL_DISGINT) begin
            gie <= 1'b0;
         end else if (irqEnter) begin
            gie <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Bit address window
   // ----------------------------------------
   // Upper address bits are dropped; the error pulse tells the core the access is void
   always_ff @(posedge clk) begin
      if (rst) begin
         bitAddr <= '0;
         bitAddrErr <= 1'b0;
      end else if (ce) begin
         bitAddrErr <= 1'b0;
         if (accept && dec.isBit) begin
            bitAddr <= operandAddr[`ICFC_BIT_ADDR_W-1:0];
            bitAddrErr <= !bitInRange(operandAddr);
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_xfer_two;
      accept && dec.isXfer
         |=> !instReady && !retire && !slotSquash && instCycles == `ICFC_CYC_LONG;
   endproperty
   a_xfer_two: assert property (p_xfer_two) else $error("transfer not two cycles");

   // The wait slot may sit frozen under a low enable, so the check waits for an enabled edge
   property p_xfer_end;
      state == ICFC_ST_WAIT && ce |=> instReady && retire && !slotSquash;
   endproperty
   a_xfer_end: assert property (p_xfer_end) else $error("second cycle did not retire");

   property p_skip_len;
      accept && dec.isSkip |=> (slotSquash == $past(skipCond)) && (retire != $past(skipCond));
   endproperty
   a_skip_len: assert property (p_skip_len) else $error("skip length wrong");

   property p_one_cycle;
      accept && !longInst |=> retire && instReady && instCycles == `ICFC_CYC_SHORT;
   endproperty
   a_one_cycle: assert property (p_one_cycle) else $error("short instr not one cycle");

   property p_all_flags;
      accept && dec.flagMask == `ICFC_MASK_ALL && !dec.isPop |=> flags == $past(aluFlags);
   endproperty
   a_all_flags: assert property (p_all_flags) else $error("four flags not updated");

   property p_zero_only;
      accept && (instClass == ICFC_CL_LOGIC || instClass == ICFC_CL_LOAD)
         |=> flags[3:1] == $past(flags[3:1]) && flags[0] == $past(aluFlags[0]);
   endproperty
   a_zero_only: assert property (p_zero_only) else $error("logic flag update wrong");

   property p_keep_flags;
      accept && dec.flagMask == `ICFC_MASK_NONE |=> $stable(flags);
   endproperty
   a_keep_flags: assert property (p_keep_flags) else $error("flags changed");

   property p_bit_window;
      accept && dec.isBit |=> bitAddrErr == ($past(operandAddr) > `ICFC_BIT_ADDR_MAX);
   endproperty
   a_bit_window: assert property (p_bit_window) else $error("bit window wrong");

   property p_reti;
      accept && instClass == ICFC_CL_RETI |=> gie && pcLoad && pcNext == $past(stackPc);
   endproperty
   a_reti: assert property (p_reti) else $error("interrupt return wrong");

   property p_pcadd;
      accept && instClass == ICFC_CL_PCADD
         |=> pcLoad && pcNext == PC_W'($past(pcCur) + PC_W'($past(acc)));
   endproperty
   a_pcadd: assert property (p_pcadd) else $error("pc add wrong");

   property p_dead_slot;
      state == ICFC_ST_WAIT && ce |=> $stable(flags) && !pcLoad;
   endproperty
   a_dead_slot: assert property (p_dead_slot) else $error("dead slot changed state");

endmodule

// ### rtl/icfc_regs.svh
`ifndef ICFC_REGS_SVH
`define ICFC_REGS_SVH

// ----------------------------------------
// Flag bit positions
// ----------------------------------------
`define ICFC_FLAG_Z 0
`define ICFC_FLAG_C 1
`define ICFC_FLAG_AC 2
`define ICFC_FLAG_OV 3

// ----------------------------------------
// Flag masks and reset values
// ----------------------------------------
`define ICFC_MASK_ALL 4'hf
`define ICFC_MASK_Z 4'h1
`define ICFC_MASK_C 4'h2
`define ICFC_MASK_NONE 4'h0
`define ICFC_FLAGS_RST 4'h0
`define ICFC_GIE_RST 1'b0

// ----------------------------------------
// Bit-addressable window
// ----------------------------------------
`define ICFC_BIT_ADDR_MAX 8'h3f
`define ICFC_BIT_ADDR_W 6

// ----------------------------------------
// Cycle counts
// ----------------------------------------
`define ICFC_CYC_LONG 2'h2
`define ICFC_CYC_SHORT 2'h1

`endif

// ### rtl/icfc_pkg.sv
package icfc_pkg;

   // ----------------------------------------
   // Instruction classes from the fetch decoder
   // ----------------------------------------
   typedef enum logic [4:0] {
      ICFC_CL_OTHER    = 5'h00,
      ICFC_CL_ARITH    = 5'h01,
      ICFC_CL_CMP_SKIP = 5'h02,
      ICFC_CL_CNT_SKIP = 5'h03,
      ICFC_CL_POPAF    = 5'h04,
      ICFC_CL_LOGIC    = 5'h05,
      ICFC_CL_LOAD     = 5'h06,
      ICFC_CL_SHIFT    = 5'h07,
      ICFC_CL_SWAPC    = 5'h08,
      ICFC_CL_BIT_SET  = 5'h09,
      ICFC_CL_BIT_SKIP = 5'h0a,
      ICFC_CL_GOTO     = 5'h0b,
      ICFC_CL_CALL     = 5'h0c,
      ICFC_CL_IDXM     = 5'h0d,
      ICFC_CL_PCADD    = 5'h0e,
      ICFC_CL_RET      = 5'h0f,
      ICFC_CL_RETI     = 5'h10,
      ICFC_CL_ENGINT   = 5'h11,
      ICFC_CL_DISGINT  = 5'h12
   } icfc_class_t;

   // ----------------------------------------
   // Sequencer states
   // ----------------------------------------
   typedef enum logic [1:0] {
      ICFC_ST_EXEC = 2'b01,
      ICFC_ST_WAIT = 2'b10
   } icfc_state_t;

endpackage

// ### rtl/icfc_dec_if.sv
`timescale 1ns/1ps
interface icfc_dec_if;
   import icfc_pkg::*;
   icfc_class_t instClass;
   logic [3:0] flagMask;
   logic isXfer;
   logic isSkip;
   logic isBit;
   logic isPop;

   modport decoder (input instClass, output flagMask, output isXfer, output isSkip,
                    output isBit, output isPop);
   modport user (output instClass, input flagMask, input isXfer, input isSkip,
                 input isBit, input isPop);
endinterface

// ### rtl/icfc_class_decode.sv
`timescale 1ns/1ps
`include "icfc_regs.svh"
module icfc_class_decode
   import icfc_pkg::*;
(
   icfc_dec_if.decoder dec
);

   // ----------------------------------------
   // Class to flag mask and timing group
   // ----------------------------------------
   always_comb begin
      dec.flagMask = `ICFC_MASK_NONE;
      dec.isXfer = 1'b0;
      dec.isSkip = 1'b0;
      dec.isBit = 1'b0;
      dec.isPop = 1'b0;
      case (dec.instClass)
         ICFC_CL_ARITH: begin
            dec.flagMask = `ICFC_MASK_ALL;
         end
         ICFC_CL_CMP_SKIP, ICFC_CL_CNT_SKIP: begin
            dec.flagMask = `ICFC_MASK_ALL;
            dec.isSkip = 1'b1;
         end
         ICFC_CL_POPAF: begin
            dec.flagMask = `ICFC_MASK_ALL;
            dec.isPop = 1'b1;
         end
         ICFC_CL_LOGIC, ICFC_CL_LOAD: begin
            dec.flagMask = `ICFC_MASK_Z;
         end
         ICFC_CL_SHIFT: begin
            dec.flagMask = `ICFC_MASK_C;
         end
         ICFC_CL_SWAPC: begin
            dec.flagMask = `ICFC_MASK_C;
            dec.isBit = 1'b1;
         end
         ICFC_CL_BIT_SET: begin
            dec.isBit = 1'b1;
         end
         ICFC_CL_BIT_SKIP: begin
            dec.isBit = 1'b1;
            dec.isSkip = 1'b1;
         end
         ICFC_CL_GOTO, ICFC_CL_CALL, ICFC_CL_IDXM, ICFC_CL_PCADD, ICFC_CL_RET,
         ICFC_CL_RETI: begin
            dec.isXfer = 1'b1;
         end
         default: begin
            dec.flagMask = `ICFC_MASK_NONE;
         end
      endcase
   end

endmodule

// ### verif/tb_top.sv
`timescale 1ns/1ps
`include "icfc_regs.svh"
module tb_top
   import icfc_pkg::*;
;
   // ----------------------------------------
   // Signals and expectation queue
   // ----------------------------------------
   typedef struct {
      logic [3:0] fl;
      logic [1:0] cyc;
      logic ie;
      logic sq;
      logic pl;
      logic [11:0] pc;
      logic isBit;
      logic be;
      logic [5:0] ba;
   } icfc_tb_exp_t;

   logic clk, rst, ce, instValid, skipCond, irqEnter;
   icfc_class_t instClass;
   logic [7:0] operandAddr, acc;
   logic [3:0] aluFlags, stackFlags;
   logic [11:0] pcCur, jumpTarget, stackPc;
   logic instReady, retire, slotSquash, gie, pcLoad, bitAddrErr;
   logic [1:0] instCycles;
   logic [3:0] flags;
   logic [11:0] pcNext;
   logic [5:0] bitAddr;
   logic sawSq, sawPl, sawBe;
   logic [3:0] flagsExp;
   logic gieExp;
   int err_count, cmp_count, cycCount;
   icfc_tb_exp_t expQ[$];

   icfc_cycle_ctrl #(.PC_W(12)) icfc_cycle_ctrl_inst (
      .clk(clk), .rst(rst), .ce(ce), .instValid(instValid), .instClass(instClass),
      .skipCond(skipCond), .operandAddr(operandAddr), .aluFlags(aluFlags),
      .stackFlags(stackFlags), .pcCur(pcCur), .acc(acc), .jumpTarget(jumpTarget),
      .stackPc(stackPc), .irqEnter(irqEnter), .instReady(instReady), .retire(retire),
      .slotSquash(slotSquash), .instCycles(instCycles), .flags(flags), .gie(gie),
      .pcLoad(pcLoad), .pcNext(pcNext), .bitAddr(bitAddr), .bitAddrErr(bitAddrErr)
   );

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ----------------------------------------
   // Checking and closing
   // ----------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Ceiling far above the few hundred cycles the stream needs
   always @(posedge clk) begin
      cycCount++;
      if (cycCount == 20000) begin
         err_count++;
         end_of_test();
      end
   end

   // Pulses are latched until retire since a 2T retire lands a cycle after them
   always @(posedge clk) begin
      icfc_tb_exp_t e;
      #1;
      if (rst === 1'b1) begin
         sawSq = 1'b0;
         sawPl = 1'b0;
         sawBe = 1'b0;
      end else begin
         sawSq = sawSq | (slotSquash === 1'b1);
         sawPl = sawPl | (pcLoad === 1'b1);
         sawBe = sawBe | (bitAddrErr === 1'b1);
         if (retire === 1'b1) begin
            if (expQ.size() == 0) begin
               check("spurious retire", 16'h1, 16'h0);
            end else begin
               e = expQ.pop_front();
               check("flags", 16'(flags), 16'(e.fl));
               check("instCycles", 16'(instCycles), 16'(e.cyc));
               check("slotSquash", 16'(sawSq), 16'(e.sq));
               check("pcLoad", 16'(sawPl), 16'(e.pl));
               if (e.pl) check("pcNext", 16'(pcNext), 16'(e.pc));
               check("gie", 16'(gie), 16'(e.ie));
               if (e.isBit) check("bitAddr", 16'(bitAddr), 16'(e.ba));
               check("bitAddrErr", 16'(sawBe), 16'(e.be));
            end
            sawSq = 1'b0;
            sawPl = 1'b0;
            sawBe = 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Driver with reference model
   // ----------------------------------------
   task automatic issue(input icfc_class_t c, input logic sk, input logic [7:0] ad);
      icfc_tb_exp_t e;
      int n;
      n = 0;
      // Stale request stays up while busy; the block must ignore it
      while (instReady !== 1'b1 && n < 10) begin
         @(negedge clk);
         n++;
      end
      instClass = c;
      skipCond = sk;
      operandAddr = ad;
      aluFlags = 4'($urandom);
      stackFlags = 4'($urandom);
      pcCur = 12'($urandom);
      acc = 8'($urandom);
      jumpTarget = 12'($urandom);
      stackPc = 12'($urandom);
      instValid = 1'b1;
      e = '{default: '0};
      case (c)
         ICFC_CL_ARITH, ICFC_CL_CMP_SKIP, ICFC_CL_CNT_SKIP: flagsExp = aluFlags;
         ICFC_CL_POPAF: flagsExp = stackFlags;
         ICFC_CL_LOGIC, ICFC_CL_LOAD: flagsExp[`ICFC_FLAG_Z] = aluFlags[`ICFC_FLAG_Z];
         ICFC_CL_SHIFT, ICFC_CL_SWAPC: flagsExp[`ICFC_FLAG_C] = aluFlags[`ICFC_FLAG_C];
         default: ;
      endcase
      e.cyc = `ICFC_CYC_SHORT;
      if (c inside {ICFC_CL_GOTO, ICFC_CL_CALL, ICFC_CL_IDXM, ICFC_CL_PCADD, ICFC_CL_RET,
                    ICFC_CL_RETI}) e.cyc = `ICFC_CYC_LONG;
      if (c inside {ICFC_CL_CMP_SKIP, ICFC_CL_CNT_SKIP, ICFC_CL_BIT_SKIP} && sk) begin
         e.cyc = `ICFC_CYC_LONG;
         e.sq = 1'b1;
      end
      e.pl = c inside {ICFC_CL_GOTO, ICFC_CL_CALL, ICFC_CL_PCADD, ICFC_CL_RET, ICFC_CL_RETI};
      if (c inside {ICFC_CL_GOTO, ICFC_CL_CALL}) e.pc = jumpTarget;
      if (c == ICFC_CL_PCADD) e.pc = pcCur + {4'h0, acc};
      if (c inside {ICFC_CL_RET, ICFC_CL_RETI}) e.pc = stackPc;
      if (c inside {ICFC_CL_RETI, ICFC_CL_ENGINT}) gieExp = 1'b1;
      if (c == ICFC_CL_DISGINT) gieExp = 1'b0;
      e.isBit = c inside {ICFC_CL_BIT_SET, ICFC_CL_BIT_SKIP, ICFC_CL_SWAPC};
      e.ba = ad[5:0];
      e.be = e.isBit && (ad > `ICFC_BIT_ADDR_MAX);
      e.fl = flagsExp;
      e.ie = gieExp;
      expQ.push_back(e);
      @(negedge clk);
   endtask

   task automatic idle(input int n);
      int k;
      instValid = 1'b0;
      for (k = 0; k < n; k++) begin
         @(negedge clk);
      end
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      icfc_class_t c;
      int i;
      logic [7:0] ad;
      rst = 1'b1;
      ce = 1'b1;
      instValid = 1'b0;
      instClass = ICFC_CL_OTHER;
      skipCond = 1'b0;
      operandAddr = 8'h00;
      aluFlags = 4'h0;
      stackFlags = 4'h0;
      pcCur = 12'h000;
      acc = 8'h00;
      jumpTarget = 12'h000;
      stackPc = 12'h000;
      irqEnter = 1'b0;
      err_count = 0;
      cmp_count = 0;
      cycCount = 0;
      flagsExp = `ICFC_FLAGS_RST;
      gieExp = `ICFC_GIE_RST;
      void'($urandom(32'h2848));
      repeat (6) @(negedge clk);
      rst = 1'b0;
      check("rst instReady", 16'(instReady), 16'h1);
      check("rst instCycles", 16'(instCycles), 16'(`ICFC_CYC_SHORT));
      check("rst flags", 16'(flags), 16'(`ICFC_FLAGS_RST));
      check("rst gie", 16'(gie), 16'(`ICFC_GIE_RST));
      // Bit window edges, then interrupt return after entry
      issue(ICFC_CL_BIT_SET, 1'b0, 8'h3f);
      issue(ICFC_CL_BIT_SET, 1'b0, 8'h40);
      issue(ICFC_CL_BIT_SKIP, 1'b1, 8'h00);
      issue(ICFC_CL_ENGINT, 1'b0, 8'h00);
      idle(2);
      irqEnter = 1'b1;
      gieExp = 1'b0;
      idle(1);
      irqEnter = 1'b0;
      issue(ICFC_CL_OTHER, 1'b0, 8'h00);
      issue(ICFC_CL_RETI, 1'b0, 8'h00);
      // A request held while the clock enable is low must not be taken
      idle(2);
      instClass = ICFC_CL_ARITH;
      aluFlags = ~flagsExp;
      ce = 1'b0;
      instValid = 1'b1;
      repeat (4) @(negedge clk);
      ce = 1'b1;
      idle(1);
      // Random back-to-back stream over every class
      for (i = 0; i < 250; i++) begin
         c = icfc_class_t'(5'($urandom % 19));
         ad = 8'($urandom);
         if (c inside {ICFC_CL_BIT_SKIP, ICFC_CL_SWAPC}) ad = ad & `ICFC_BIT_ADDR_MAX;
         issue(c, 1'($urandom), ad);
      end
      idle(4);
      check("queue drained", 16'(expQ.size()), 16'h0);
      end_of_test();
   end
endmodule
